// ---- rsc_reset_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl #(
  parameter int unsigned MCD_TIMEOUT_CYC = rsc_pkg::RSC_MCD_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe,
  input wire logic vdd_mon_en,
  input wire logic vdd_ok,
  input wire logic cmp_out,
  input wire logic wdt_timeout,
  input wire logic flash_req,
  input wire logic [15:0] flash_addr,
  input wire logic flash_denied,
  input wire logic sysclk_in,
  output logic core_rst_n,
  output logic [15:0] core_boot_addr
);
  localparam rsc_pkg::rsc_ctrl_t RST_Q = '{
    st: rsc_pkg::RSC_DELAY,
    dly: '0,
    flags: rsc_pkg::RSC_FLAGS_RST,
    cmp_en: rsc_pkg::RSC_CMP_EN_RST,
    mcd_en: rsc_pkg::RSC_MCD_EN_RST,
    vdd_sel: rsc_pkg::RSC_VDD_SEL_RST,
    core_rst_n: 1'b0,
    pin_oe: 1'b1,
    rdata: 8'h00,
    boot_addr: rsc_pkg::RSC_BOOT_ADDR
  };

  function automatic logic [7:0] flag_mask(input int unsigned pos);
    logic [7:0] m;
    m = 8'h00;
    m[pos[2:0]] = 1'b1;
    return m;
  endfunction

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_sync_n;

  rsc_pkg::rsc_ctrl_t q_ff;
  rsc_pkg::rsc_ctrl_t nxt_q;

  logic hit;
  logic wr_ok;
  logic sw_force;
  logic vdd_low;
  logic pin_low;
  logic cmp_low;
  logic mcd_to;
  logic flash_fault;
  logic any_lvl;
  logic any_src;
  logic [7:0] cause;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_sync_n = rst_sync_ff;

  rsc_miss_clk #(
    .TIMEOUT_CYC(MCD_TIMEOUT_CYC)
  ) u_miss_clk (
    .mclk(mclk),
    .rst_n(rst_sync_n),
    .ce(ce),
    .enable(q_ff.mcd_en),
    .sysclk_in(sysclk_in),
    .timeout(mcd_to)
  );

  assign hit = sfr_addr == rsc_pkg::RSC_REG_ADDR;
  // Writes from a core held in reset cannot happen; ignore bus noise then
  assign wr_ok = sfr_wr && hit && q_ff.core_rst_n;
  assign sw_force = wr_ok && sfr_wdata[rsc_pkg::RSC_BIT_SW];
  assign vdd_low = q_ff.vdd_sel && vdd_mon_en && !vdd_ok;
  // Our own pin drive reads back low; it must not look like an external reset
  assign pin_low = !rst_pin_in && !q_ff.pin_oe;
  assign cmp_low = q_ff.cmp_en && !cmp_out;
  assign flash_fault = flash_req
    && (flash_addr > rsc_pkg::RSC_FLASH_LIMIT || flash_denied);
  assign any_lvl = vdd_low || pin_low || cmp_low;
  assign any_src = any_lvl || mcd_to || wdt_timeout || flash_fault || sw_force;

  always_comb
  begin
    // Supply loss keeps other flags, which then carry no meaning
    if (vdd_low)
      cause = q_ff.flags | flag_mask(rsc_pkg::RSC_BIT_POR);
    else if (pin_low)
      cause = flag_mask(rsc_pkg::RSC_BIT_PIN);
    else if (cmp_low)
      cause = flag_mask(rsc_pkg::RSC_BIT_CMP);
    else if (mcd_to)
      cause = flag_mask(rsc_pkg::RSC_BIT_MCD);
    else if (wdt_timeout)
      cause = flag_mask(rsc_pkg::RSC_BIT_WDT);
    else if (flash_fault)
      cause = flag_mask(rsc_pkg::RSC_BIT_FLASH);
    else
      cause = flag_mask(rsc_pkg::RSC_BIT_SW);
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.pin_oe = 1'b0;
    nxt_q.boot_addr = rsc_pkg::RSC_BOOT_ADDR;
    nxt_q.rdata = (sfr_rd && hit) ? q_ff.flags : 8'h00;
    if (wr_ok)
    begin
      nxt_q.cmp_en = sfr_wdata[rsc_pkg::RSC_BIT_CMP];
      nxt_q.mcd_en = sfr_wdata[rsc_pkg::RSC_BIT_MCD];
      nxt_q.vdd_sel = sfr_wdata[rsc_pkg::RSC_BIT_POR];
    end
    unique case (q_ff.st)
      rsc_pkg::RSC_HOLD:
      begin
        nxt_q.pin_oe = vdd_low;
        if (!any_lvl)
        begin
          nxt_q.st = rsc_pkg::RSC_DELAY;
          nxt_q.dly = '0;
        end
      end
      rsc_pkg::RSC_RUN,
      rsc_pkg::RSC_DELAY:
      begin
        if (q_ff.st == rsc_pkg::RSC_DELAY)
        begin
          if (q_ff.dly == rsc_pkg::RSC_DLY_W'(rsc_pkg::RSC_RST_DELAY_CYC - 1))
          begin
            nxt_q.st = rsc_pkg::RSC_RUN;
            nxt_q.core_rst_n = 1'b1;
          end
          else
          begin
            nxt_q.dly = q_ff.dly + 1'b1;
          end
        end
        // A new source during the release delay starts the sequence again
        if (any_src)
        begin
          nxt_q.st = rsc_pkg::RSC_HOLD;
          nxt_q.core_rst_n = 1'b0;
          nxt_q.pin_oe = vdd_low;
          nxt_q.flags = cause;
        end
      end
    endcase
    nxt_q.flags[rsc_pkg::RSC_BIT_UNUSED] = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      q_ff <= RST_Q;
    else if (ce)
      q_ff <= nxt_q;
  end

  assign sfr_rdata = q_ff.rdata;
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe = q_ff.pin_oe;
  assign core_rst_n = q_ff.core_rst_n;
  assign core_boot_addr = q_ff.boot_addr;

  // Counts release-delay cycles for the delay check
  logic [rsc_pkg::RSC_DLY_W:0] gap_cnt_ff;

  always_ff @(posedge mclk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      gap_cnt_ff <= '0;
    else if (ce)
      gap_cnt_ff <= (q_ff.st == rsc_pkg::RSC_DELAY) ? gap_cnt_ff + 1'b1 : '0;
  end

  default clocking ctl_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_n);

  chk_bit7_zero: assert property (
    !sfr_rdata[7] && !q_ff.flags[7])
    else $error("unused bit 7 not zero");
  chk_read_flags: assert property (
    (ce && sfr_rd && hit) |=> sfr_rdata == $past(q_ff.flags))
    else $error("register read does not return cause flags");
  chk_cfg_write: assert property (
    (ce && wr_ok) |=> q_ff.cmp_en == $past(sfr_wdata[5])
      && q_ff.mcd_en == $past(sfr_wdata[2]) && q_ff.vdd_sel == $past(sfr_wdata[1]))
    else $error("enable bits not taken from write");
  chk_sw_force: assert property (
    (ce && sw_force && !any_lvl && !mcd_to && !wdt_timeout && !flash_fault
      && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> !core_rst_n && q_ff.flags == 8'h10)
    else $error("software force did not reset with single flag");
  chk_wdt_cause: assert property (
    (ce && wdt_timeout && !any_lvl && !mcd_to && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> q_ff.flags == 8'h08 ##1 !core_rst_n)
    else $error("watchdog reset flag wrong");
  chk_flash_limit: assert property (
    (ce && flash_req && flash_addr > rsc_pkg::RSC_FLASH_LIMIT && !any_lvl && !mcd_to
      && !wdt_timeout && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> q_ff.flags == 8'h40 && !core_rst_n)
    else $error("flash access above limit did not reset");
  chk_pin_por_clr: assert property (
    (ce && pin_low && !vdd_low && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> !q_ff.flags[1] && q_ff.flags[0])
    else $error("pin reset left power-on flag set");
  chk_pin_drive: assert property (
    rst_pin_oe |-> q_ff.flags[1] && !core_rst_n)
    else $error("pin driven by a non-supply reset");
  chk_release_dly: assert property (
    $rose(core_rst_n)
    |-> gap_cnt_ff == (rsc_pkg::RSC_DLY_W + 1)'(rsc_pkg::RSC_RST_DELAY_CYC)
      && core_boot_addr == rsc_pkg::RSC_BOOT_ADDR)
    else $error("core released before delay elapsed");
  chk_mcd_cause: assert property (
    (ce && mcd_to && !any_lvl && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> q_ff.flags == 8'h04)
    else $error("missing clock reset flag wrong");
  chk_hold_core: assert property (
    (q_ff.st == rsc_pkg::RSC_HOLD) |-> !core_rst_n)
    else $error("core running while a source is held");
  chk_level_hold: assert property (
    (ce && q_ff.st == rsc_pkg::RSC_HOLD && any_lvl) |=> q_ff.st == rsc_pkg::RSC_HOLD)
    else $error("hold left while a level source persists");
  chk_por_clear: assert property (
    (ce && any_src && !vdd_low && q_ff.st != rsc_pkg::RSC_HOLD)
    |=> !q_ff.flags[rsc_pkg::RSC_BIT_POR])
    else $error("power-on flag kept after another reset");

  cov_sw_reset: cover property (sw_force ##1 !core_rst_n);
  cov_pin_reset: cover property (pin_low ##1 q_ff.flags == 8'h01);
  cov_vdd_reset: cover property (vdd_low ##1 rst_pin_oe);
  cov_release: cover property ($rose(core_rst_n));
endmodule
`default_nettype wire

// ---- rsc_pkg.sv ----
package rsc_pkg;

  localparam logic [7:0] RSC_REG_ADDR = 8'hEF;

  localparam int unsigned RSC_BIT_UNUSED = 7;
  localparam int unsigned RSC_BIT_FLASH = 6;
  localparam int unsigned RSC_BIT_CMP = 5;
  localparam int unsigned RSC_BIT_SW = 4;
  localparam int unsigned RSC_BIT_WDT = 3;
  localparam int unsigned RSC_BIT_MCD = 2;
  localparam int unsigned RSC_BIT_POR = 1;
  localparam int unsigned RSC_BIT_PIN = 0;

  localparam logic [7:0] RSC_FLAGS_RST = 8'h02;
  localparam logic RSC_CMP_EN_RST = 1'b0;
  localparam logic RSC_MCD_EN_RST = 1'b0;
  localparam logic RSC_VDD_SEL_RST = 1'b1;

  localparam logic [15:0] RSC_FLASH_LIMIT = 16'h1DFF;
  localparam logic [15:0] RSC_BOOT_ADDR = 16'h0000;

  localparam int unsigned RSC_CLK_PERIOD_NS = 8;
  localparam int unsigned RSC_RST_DELAY_NS = 5000;
  localparam int unsigned RSC_RST_DELAY_CYC =
    (RSC_RST_DELAY_NS + RSC_CLK_PERIOD_NS - 1) / RSC_CLK_PERIOD_NS;
  localparam int unsigned RSC_DLY_W = $clog2(RSC_RST_DELAY_CYC + 1);
  localparam int unsigned RSC_MCD_MIN_US = 100;
  localparam int unsigned RSC_MCD_TYP_US = 220;
  localparam int unsigned RSC_MCD_MAX_US = 600;
  localparam int unsigned RSC_MCD_TIMEOUT_CYC =
    RSC_MCD_TYP_US * 1000 / RSC_CLK_PERIOD_NS;
  localparam int unsigned RSC_PIN_LOW_MIN_US = 15;
  localparam int unsigned RSC_VDD_SETTLE_US = 100;

  typedef enum logic [1:0] {
    RSC_RUN,
    RSC_HOLD,
    RSC_DELAY
  } rsc_state_t;

  typedef struct packed {
    rsc_state_t st;
    logic [RSC_DLY_W-1:0] dly;
    logic [7:0] flags;
    logic cmp_en;
    logic mcd_en;
    logic vdd_sel;
    logic core_rst_n;
    logic pin_oe;
    logic [7:0] rdata;
    logic [15:0] boot_addr;
  } rsc_ctrl_t;

endpackage

// ---- rsc_miss_clk.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_miss_clk #(
  parameter int unsigned TIMEOUT_CYC = rsc_pkg::RSC_MCD_TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic enable,
  input wire logic sysclk_in,
  output logic timeout
);
  localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

  typedef struct packed {
    logic prev;
    logic [CW-1:0] cnt;
    logic timeout;
  } rsc_mcd_t;

  rsc_mcd_t q_ff;
  rsc_mcd_t nxt_q;
  logic rise;

  assign rise = sysclk_in && !q_ff.prev;
  assign timeout = q_ff.timeout;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.prev = sysclk_in;
    nxt_q.timeout = 1'b0;
    // Stuck high and stuck low both show as no rising edge
    if (!enable || rise)
    begin
      nxt_q.cnt = '0;
    end
    else if (q_ff.cnt == CW'(TIMEOUT_CYC - 1))
    begin
      nxt_q.cnt = '0;
      nxt_q.timeout = 1'b1;
    end
    else
    begin
      nxt_q.cnt = q_ff.cnt + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '0;
    else if (ce)
      q_ff <= nxt_q;
  end

  default clocking mcd_cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  chk_mcd_fires: assert property (
    (ce && enable && !rise && q_ff.cnt == CW'(TIMEOUT_CYC - 1)) |=> timeout)
    else $error("missing clock timeout not raised");
  chk_mcd_disabled: assert property (
    (ce && !enable) |=> !timeout)
    else $error("missing clock timeout while disabled");
  cov_mcd_timeout: cover property (timeout);
endmodule
`default_nettype wire

// ---- rsc_far_side.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_far_side (
  input wire logic mclk,
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic pin_req,
  input wire logic sck_run,
  output logic pin_lvl,
  output logic sck
);
  localparam int PIN_CYC = rsc_pkg::RSC_PIN_LOW_MIN_US * 1000 / rsc_pkg::RSC_CLK_PERIOD_NS;
  int hold = 0;
  logic [1:0] div = 2'h0;
  // Outside party keeps the line low long enough to count
  always @(posedge mclk)
    if (pin_req)
      hold <= PIN_CYC;
    else if (hold > 0)
      hold <= hold - 1;
  // Pull-up wins unless some party sinks the line
  assign pin_lvl = !((hold > 0) || (pin_oe && !pin_out));
  // Stands still while stopped, so the detector can fire
  always @(posedge mclk)
    if (sck_run)
      div <= div + 2'h1;
  assign sck = div[1];
endmodule
`default_nettype wire

// ---- rsc_reset_ctrl_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module rsc_reset_ctrl_bench;
  logic mclk, rst_n, ce, sfr_wr, sfr_rd, rst_pin_in, rst_pin_out, rst_pin_oe;
  logic vdd_mon_en, vdd_ok, cmp_out, wdt_timeout, flash_req, flash_denied;
  logic sysclk_in, core_rst_n, pin_req, sck_run;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, d;
  logic [15:0] flash_addr, core_boot_addr;
  int fail_count = 0;
  int checks = 0;
  int n;

  rsc_reset_ctrl #(.MCD_TIMEOUT_CYC(20)) i_dut (.mclk(mclk), .rst_n(rst_n), .ce(ce),
    .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out),
    .rst_pin_oe(rst_pin_oe), .vdd_mon_en(vdd_mon_en), .vdd_ok(vdd_ok), .cmp_out(cmp_out),
    .wdt_timeout(wdt_timeout), .flash_req(flash_req), .flash_addr(flash_addr),
    .flash_denied(flash_denied), .sysclk_in(sysclk_in), .core_rst_n(core_rst_n),
    .core_boot_addr(core_boot_addr));
  rsc_far_side i_far (.mclk(mclk), .pin_oe(rst_pin_oe), .pin_out(rst_pin_out),
    .pin_req(pin_req), .sck_run(sck_run), .pin_lvl(rst_pin_in), .sck(sysclk_in));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask

  task automatic end_sim();
    $display("errors %0d checks %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge mclk);
    sfr_rd <= 1'b1;
    sfr_addr <= a;
    @(posedge mclk);
    sfr_rd <= 1'b0;
    #1 d = sfr_rdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    sfr_wr <= 1'b1;
    sfr_addr <= a;
    sfr_wdata <= v;
    @(posedge mclk);
    sfr_wr <= 1'b0;
  endtask

  task automatic wait_up();
    n = 0;
    while (core_rst_n !== 1'b1 && n < 4000)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 4000)
    begin
      fail_count++;
      end_sim();
    end
  endtask

  task automatic idle_chk(input int c);
    repeat (c) @(posedge mclk);
    #1 chk(core_rst_n, 1'b1);
  endtask

  // Expects the core held from two edges on, then a full release delay
  task automatic rst_case(input logic [7:0] e);
    repeat (2) @(posedge mclk);
    #1 chk(core_rst_n, 1'b0);
    chk(rst_pin_oe, 1'b0);
    wait_up();
    chk(16'(n + 1 >= 625), 16'h1);
    chk(core_boot_addr, 16'h0000);
    rd(8'hEF);
    chk(d, e);
  endtask

  initial
  begin
    #200000;
    fail_count++;
    end_sim();
  end

  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    {sfr_wr, sfr_rd, wdt_timeout, flash_req, flash_denied, pin_req} = 6'h00;
    sfr_addr = 8'hEF;
    sfr_wdata = 8'h00;
    flash_addr = 16'h0000;
    // Monitor on and settled before reset ends, since reset already selects it
    vdd_mon_en = 1'b1;
    vdd_ok = 1'b1;
    cmp_out = 1'b1;
    sck_run = 1'b1;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    wait_up();
    rd(8'hEF);
    chk(d, 8'h02);
    rd(8'hEE);
    chk(d, 8'h00);
    wr(8'hEE, 8'h10);
    idle_chk(3);
    wr(8'hEF, 8'h90);
    rst_case(8'h10);
    @(posedge mclk);
    wdt_timeout <= 1'b1;
    @(posedge mclk);
    wdt_timeout <= 1'b0;
    rst_case(8'h08);
    for (int i = 0; i < 3; i++)
    begin
      @(posedge mclk);
      flash_req <= 1'b1;
      flash_addr <= i == 0 ? 16'h1E00 : (i == 1 ? 16'h0000 : 16'h1DFF);
      flash_denied <= i == 1;
      @(posedge mclk);
      flash_req <= 1'b0;
      if (i < 2)
        rst_case(8'h40);
    end
    idle_chk(3);
    wr(8'hEF, 8'h20);
    cmp_out <= 1'b0;
    @(posedge mclk);
    cmp_out <= 1'b1;
    rst_case(8'h20);
    wr(8'hEF, 8'h00);
    cmp_out <= 1'b0;
    idle_chk(3);
    cmp_out <= 1'b1;
    sck_run <= 1'b0;
    idle_chk(40);
    wr(8'hEF, 8'h04);
    // Clock already stopped; 20 cycles up to the timeout flag, one to latch
    n = 0;
    while (core_rst_n === 1'b1 && n < 40)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(16'(n), 16'd21);
    // Restart before the detector can fire a second time
    sck_run <= 1'b1;
    rst_case(8'h04);
    wr(8'hEF, 8'h00);
    @(posedge mclk);
    pin_req <= 1'b1;
    @(posedge mclk);
    pin_req <= 1'b0;
    repeat (8) @(posedge mclk);
    rst_case(8'h01);
    vdd_ok <= 1'b0;
    idle_chk(3);
    vdd_ok <= 1'b1;
    wr(8'hEF, 8'h02);
    vdd_ok <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk(rst_pin_oe, 1'b1);
    chk(rst_pin_out, 1'b0);
    chk(core_rst_n, 1'b0);
    vdd_ok <= 1'b1;
    wait_up();
    rd(8'hEF);
    chk(d & 8'h82, 8'h02);
    end_sim();
  end
endmodule
`default_nettype wire
